//--- core/lcdr_reset_seq.sv
// Purpose: system reset sequencing of an LCD segment driver with key scan and general outputs
// Assumes: supply_drop_detector is high while supply is at or under threshold; software sends
//   the control word and the four display groups over Avalon-MM after each system reset
// Notes: serial side registers (control, display latch) are never cleared by the system reset
// Notes on behaviour
// RULE1: system reset comes from the supply drop detector, at power-up and on droop.
// RULE2: during system reset display stays off, common and segment drivers reset.
// RULE3: display turns on only after control word and all four display groups arrive.
// RULE4: control word enables key scanning and releases cleared key data.
// RULE5: control word releases port low lock, ports follow their control bits.
// RULE6: clock generator held in reset, base clock stopped, during system reset.
// RULE7: oscillator sleep or normal mode decided only after sleep select arrives.
// RULE8: display data still accepted into the latch while display forced off.
// RULE9: contrast adjust disabled by reset until level and enable bits arrive.
// RULE10: key scan and key buffer forcibly initialised, scanning halted, on reset.
// RULE11: all key data bits cleared to zero on system reset.
// RULE12: general outputs driven and held low during system reset.
// RULE13: serial interface, shift and control registers excluded from system reset.
// RULE14: key data output released high in reset and before key scan bits arrive.
// RULE15: segment and common at lowest level, key scan and port outputs low in reset.
// RULE16: controller sends control word then four display groups after each reset.
`timescale 1ns/1ps
`include "lcdr_regs.svh"
module lcdr_reset_seq import lcdr_pkg::*; #(
	parameter int KEY_BITS = 30,
	parameter int FILT_CYC = `LCDR_DET_FILT_CYC
) (
	// clock and bus reset
	input wire logic clk_sys,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// supply detector pin
	input wire logic supply_drop_detector,
	// key scan side
	input wire logic key_event,
	input wire logic [29:0] key_event_data,
	output logic [5:0] key_scan_outputs,
	output logic key_data_out_o,
	output logic key_data_out_oe,
	// general outputs and display control
	output logic [3:0] general_outputs,
	output logic display_on,
	output logic lcd_drive_reset,
	output logic clk_gen_reset,
	output logic rc_oscillator_pin,
	output logic osc_sleep,
	output logic contrast_enable_o,
	output logic [3:0] contrast_level_o,
	output logic [1:0] duty_select_o
);
	typedef struct packed {
		lcdr_state_t state;
		logic [7:0] filt_cnt;
		logic [`LCDR_DISP_GROUPS-1:0] grp_seen;
		logic ctrl_seen;
		logic [29:0] key_buf;
		logic key_pending;
		logic [31:0] rdata;
		logic ack;
		logic osc_div;
	} lcdr_core_t;
	// serial side state kept apart so system reset never touches it
	typedef struct packed {
		logic [5:0] key_scan_output_ctrl;
		logic [3:0] port_level_ctrl;
		logic [3:0] contrast_level;
		logic contrast_adjust_enable;
		logic segment_on_off_ctrl;
		logic sleep_select;
		logic duty_select_lo;
		logic duty_select_hi;
		logic [`LCDR_DISP_GROUPS-1:0] [29:0] disp_word;
	} lcdr_ser_t;
	lcdr_core_t core_r;
	lcdr_core_t core_nxt;
	lcdr_ser_t ser_r;
	lcdr_ser_t ser_nxt;
	logic det_lvl;
	logic sys_rst;
	logic wr_ctrl;
	logic wr_disp;
	logic [1:0] grp_idx;
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction
	lcdr_sync u_det_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(supply_drop_detector),
		.level_out(det_lvl)
	);
	// detector level is held in reset for FILT_CYC+1 cycles after it falls
	assign sys_rst = (core_r.state == LCDR_ST_RESET); // see RULE1
	assign avs_waitrequest = (avs_read | avs_write) & ~core_r.ack;
	// writes land on the edge that sees waitrequest low, never while the master still waits
	assign wr_ctrl = avs_write & core_r.ack & (avs_address == `LCDR_OFS_CTRL);
	assign wr_disp = avs_write & core_r.ack & (avs_address == `LCDR_OFS_DISP);
	assign grp_idx = avs_writedata[`LCDR_DISP_GRP_LSB +: 2];
	always_comb begin
		logic [31:0] merged;
		merged = 32'h0000_0000;
		core_nxt = core_r;
		ser_nxt = ser_r;
		core_nxt.ack = (avs_read | avs_write) & ~core_r.ack;
		core_nxt.osc_div = ~core_r.osc_div;
		// control and display latch always writable, reset or not
		if (wr_ctrl) begin // see RULE13
			merged = be_merge({13'h0000, ser_r.duty_select_hi, ser_r.duty_select_lo, ser_r.sleep_select,
				ser_r.segment_on_off_ctrl, ser_r.contrast_adjust_enable, ser_r.contrast_level,
				ser_r.port_level_ctrl, ser_r.key_scan_output_ctrl}, avs_writedata, avs_byteenable);
			ser_nxt.key_scan_output_ctrl = merged[`LCDR_CTRL_KSC_LSB +: 6];
			ser_nxt.port_level_ctrl = merged[`LCDR_CTRL_PORT_LSB +: 4];
			ser_nxt.contrast_level = merged[`LCDR_CTRL_CTL_LSB +: 4];
			ser_nxt.contrast_adjust_enable = merged[`LCDR_CTRL_CTE_BIT];
			ser_nxt.segment_on_off_ctrl = merged[`LCDR_CTRL_SEG_BIT];
			ser_nxt.sleep_select = merged[`LCDR_CTRL_SLP_BIT];
			ser_nxt.duty_select_lo = merged[`LCDR_CTRL_DT_LSB];
			ser_nxt.duty_select_hi = merged[`LCDR_CTRL_DT_LSB + 1];
		end
		if (wr_disp) begin // see RULE8
			ser_nxt.disp_word[grp_idx] = avs_writedata[29:0];
		end
		case (core_r.state)
			LCDR_ST_RESET: begin
				core_nxt.ctrl_seen = 1'b0;
				core_nxt.grp_seen = '0;
				core_nxt.key_buf = '0; // see RULE11
				core_nxt.key_pending = 1'b0; // see RULE10
				if (det_lvl) begin
					core_nxt.filt_cnt = 8'(FILT_CYC);
				end else if (core_r.filt_cnt != 8'h00) begin
					core_nxt.filt_cnt = core_r.filt_cnt - 8'h01;
				end else begin
					core_nxt.state = LCDR_ST_CTRL_WAIT;
				end
			end
			LCDR_ST_CTRL_WAIT, LCDR_ST_RUN: begin
				if (wr_ctrl) begin
					core_nxt.ctrl_seen = 1'b1;
				end
				if (wr_disp) begin
					core_nxt.grp_seen[grp_idx] = 1'b1;
				end
				if (core_r.ctrl_seen && &core_r.grp_seen) begin // see RULE3
					core_nxt.state = LCDR_ST_RUN;
				end
				// key scan runs only once control word is in; new event wins over read clear
				if (core_r.ctrl_seen) begin // see RULE4
					if (avs_read && !core_r.ack && avs_address == `LCDR_OFS_KEY) begin
						core_nxt.key_pending = 1'b0;
					end
					if (key_event) begin
						core_nxt.key_buf = key_event_data;
						core_nxt.key_pending = 1'b1;
					end
				end
				if (det_lvl) begin // see RULE1
					core_nxt.state = LCDR_ST_RESET;
					core_nxt.filt_cnt = 8'(FILT_CYC);
					// clear on entry so ports and key out drop in the first reset cycle
					core_nxt.ctrl_seen = 1'b0; // see RULE12
					core_nxt.grp_seen = '0; // see RULE2
					core_nxt.key_buf = '0; // see RULE11
					core_nxt.key_pending = 1'b0; // see RULE10
				end
			end
			default: begin
				core_nxt.state = LCDR_ST_RESET;
			end
		endcase
		core_nxt.rdata = 32'h0000_0000;
		if ((avs_read | avs_write) && !core_r.ack) begin
			case (avs_address)
				`LCDR_OFS_CTRL: core_nxt.rdata = {13'h0000, ser_r.duty_select_hi, ser_r.duty_select_lo,
					ser_r.sleep_select, ser_r.segment_on_off_ctrl, ser_r.contrast_adjust_enable,
					ser_r.contrast_level, ser_r.port_level_ctrl, ser_r.key_scan_output_ctrl};
				`LCDR_OFS_STAT: core_nxt.rdata = {24'h00_0000, core_r.key_pending, core_r.grp_seen,
					core_r.ctrl_seen, display_on, sys_rst};
				`LCDR_OFS_KEY: core_nxt.rdata = {2'b00, core_r.key_buf};
				default: core_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_r <= '{state: LCDR_ST_RESET, filt_cnt: 8'h00, grp_seen: '0, ctrl_seen: 1'b0,
				key_buf: '0, key_pending: 1'b0, rdata: `LCDR_STAT_RST, ack: 1'b0, osc_div: 1'b0};
		end else begin
			core_r <= core_nxt;
		end
	end
	// deliberately no reset: serial side must take data at any time
	always_ff @(posedge clk_sys) begin // see RULE13
		ser_r <= ser_nxt;
	end
	assign avs_readdata = core_r.rdata;
	assign display_on = (core_r.state == LCDR_ST_RUN) & ~ser_r.segment_on_off_ctrl; // see RULE2
	assign lcd_drive_reset = (core_r.state != LCDR_ST_RUN); // see RULE15
	assign clk_gen_reset = sys_rst; // see RULE6
	assign rc_oscillator_pin = ~sys_rst & core_r.ctrl_seen & ~ser_r.sleep_select & core_r.osc_div;
	assign osc_sleep = core_r.ctrl_seen & ser_r.sleep_select; // see RULE7
	assign contrast_enable_o = core_r.ctrl_seen & ser_r.contrast_adjust_enable; // see RULE9
	assign contrast_level_o = core_r.ctrl_seen ? ser_r.contrast_level : 4'h0;
	assign duty_select_o = core_r.ctrl_seen ? {ser_r.duty_select_hi, ser_r.duty_select_lo} : 2'b00;
	assign key_scan_outputs = core_r.ctrl_seen ? ser_r.key_scan_output_ctrl : 6'h00; // see RULE15
	assign general_outputs = core_r.ctrl_seen ? ser_r.port_level_ctrl : 4'h0; // see RULE5 RULE12
	assign key_data_out_o = 1'b0;
	assign key_data_out_oe = core_r.ctrl_seen & core_r.key_pending; // see RULE14
	a_ports_low_rst: assert property (@(posedge clk_sys) disable iff (rst)
		sys_rst |-> general_outputs == 4'h0 && key_scan_outputs == 6'h00) // see RULE12
		else $error("ports not low in reset");
	a_disp_off_rst: assert property (@(posedge clk_sys) disable iff (rst)
		sys_rst |-> !display_on && lcd_drive_reset) // see RULE2
		else $error("display on in reset");
	a_det_enters_rst: assert property (@(posedge clk_sys) disable iff (rst)
		det_lvl |=> sys_rst) // see RULE1
		else $error("detector did not reset");
	a_run_needs_all: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(core_r.state == LCDR_ST_RUN) |-> $past(core_r.ctrl_seen) && $past(&core_r.grp_seen)) // see RULE3
		else $error("display on before full data");
	a_key_clear_rst: assert property (@(posedge clk_sys) disable iff (rst)
		sys_rst |=> core_r.key_buf == 30'h0 || !sys_rst) // see RULE11
		else $error("key data not cleared");
	a_do_released: assert property (@(posedge clk_sys) disable iff (rst)
		!core_r.ctrl_seen |-> !key_data_out_oe) // see RULE14
		else $error("key out driven early");
	a_clk_gen_stop: assert property (@(posedge clk_sys) disable iff (rst)
		sys_rst |-> clk_gen_reset && !rc_oscillator_pin) // see RULE6
		else $error("clock runs in reset");
	a_contrast_off: assert property (@(posedge clk_sys) disable iff (rst)
		!core_r.ctrl_seen |-> !contrast_enable_o && !osc_sleep) // see RULE9 RULE7
		else $error("contrast or sleep before control");
	a_ctrl_kept_rst: assert property (@(posedge clk_sys) disable iff (rst)
		sys_rst && wr_ctrl |=> ser_r.port_level_ctrl == $past(avs_writedata[9:6]) || !$past(avs_byteenable[0])
		|| !$past(avs_byteenable[1])) // see RULE13
		else $error("control write lost in reset");
	a_wait_one: assert property (@(posedge clk_sys) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held too long");
	a_disp_latch_take: assert property (@(posedge clk_sys) disable iff (rst) // see RULE8
		wr_disp |=> ser_r.disp_word[$past(grp_idx)] == $past(avs_writedata[29:0]))
		else $error("display latch write lost");
	a_key_oe_rst: assert property (@(posedge clk_sys) disable iff (rst) // see RULE14
		sys_rst |-> !key_data_out_oe)
		else $error("key out driven in reset");
	a_key_pend_clr: assert property (@(posedge clk_sys) disable iff (rst) // see RULE10
		sys_rst |=> !core_r.key_pending || !sys_rst)
		else $error("key pending kept in reset");
	a_scan_off_early: assert property (@(posedge clk_sys) disable iff (rst) // see RULE4
		!core_r.ctrl_seen |-> key_scan_outputs == 6'h00)
		else $error("key scan before control");
	a_ports_follow: assert property (@(posedge clk_sys) disable iff (rst) // see RULE5
		core_r.ctrl_seen |-> general_outputs == ser_r.port_level_ctrl)
		else $error("ports ignore control bits");
	a_sleep_gated: assert property (@(posedge clk_sys) disable iff (rst) // see RULE7
		core_r.ctrl_seen |-> osc_sleep == ser_r.sleep_select)
		else $error("sleep mode not from control");
	a_contrast_lvl: assert property (@(posedge clk_sys) disable iff (rst) // see RULE9
		!core_r.ctrl_seen |-> contrast_level_o == 4'h0)
		else $error("contrast level before control");
	a_lcd_low_rst: assert property (@(posedge clk_sys) disable iff (rst) // see RULE15
		sys_rst |-> lcd_drive_reset && key_scan_outputs == 6'h00)
		else $error("lcd or scan outputs live in reset");
	a_det_clears_ctrl: assert property (@(posedge clk_sys) disable iff (rst) // see RULE4
		det_lvl && !sys_rst |=> !core_r.ctrl_seen)
		else $error("control kept over droop");
	a_grp_clr_rst: assert property (@(posedge clk_sys) disable iff (rst) // see RULE3
		sys_rst |-> core_r.grp_seen == '0)
		else $error("display groups kept in reset");
	a_ctrl_seen_rst: assert property (@(posedge clk_sys) disable iff (rst) // see RULE4
		sys_rst |-> !core_r.ctrl_seen)
		else $error("control seen in reset");
	a_key_zero_rst: assert property (@(posedge clk_sys) disable iff (rst) // see RULE11
		sys_rst |-> core_r.key_buf == 30'h0)
		else $error("key data not zero in reset");
	a_ack_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		core_r.ack |=> !core_r.ack)
		else $error("ack longer than one cycle");
	a_wait_low_ack: assert property (@(posedge clk_sys) disable iff (rst)
		(avs_read || avs_write) && !avs_waitrequest |-> core_r.ack)
		else $error("waitrequest low without ack");
	a_filt_hold: assert property (@(posedge clk_sys) disable iff (rst) // see RULE1
		sys_rst && det_lvl |=> sys_rst && core_r.filt_cnt == 8'(FILT_CYC))
		else $error("reset left while detector high");
	a_disp_needs_ctrl: assert property (@(posedge clk_sys) disable iff (rst) // see RULE3
		display_on |-> core_r.ctrl_seen && !ser_r.segment_on_off_ctrl)
		else $error("display on without control");
	a_ctrl_lands: assert property (@(posedge clk_sys) disable iff (rst) // see RULE13
		wr_ctrl && avs_byteenable == 4'hf |=> ser_r.key_scan_output_ctrl == $past(avs_writedata[5:0]))
		else $error("control write lost");
	a_duty_gated: assert property (@(posedge clk_sys) disable iff (rst)
		!core_r.ctrl_seen |-> duty_select_o == 2'b00)
		else $error("duty before control");
	a_oe_needs_key: assert property (@(posedge clk_sys) disable iff (rst) // see RULE14
		key_data_out_oe |-> core_r.key_pending)
		else $error("key out driven with no key");
endmodule

//--- core/lcdr_sync.sv
// Purpose: three-stage synchroniser for a pin input, change accepted when stages two and three agree
// Assumes: single clock clk_sys
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
module lcdr_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pin in, filtered level out
	input wire logic pin_in,
	output logic level_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} lcdr_sync_st_t;
	lcdr_sync_st_t st_r;
	lcdr_sync_st_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
		end
	end
	// pin reads as in-detection (1) at reset: power-up counts as a drop
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= 4'hF;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign level_out = st_r.lvl;
endmodule

//--- pkg/lcdr_pkg.sv
// Purpose: types shared by the reset sequencer
// Assumes: nothing beyond the regs header
// Notes: none
package lcdr_pkg;
	typedef enum logic [2:0] {
		LCDR_ST_RESET = 3'b001,
		LCDR_ST_CTRL_WAIT = 3'b010,
		LCDR_ST_RUN = 3'b100
	} lcdr_state_t;
endpackage

//--- pkg/lcdr_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the reset sequencer
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes: control word fields follow the serial control data layout of this block
`ifndef LCDR_REGS_SVH
`define LCDR_REGS_SVH
`define LCDR_OFS_CTRL 4'h0
`define LCDR_OFS_DISP 4'h4
`define LCDR_OFS_STAT 4'h8
`define LCDR_OFS_KEY 4'hC
`define LCDR_CTRL_KSC_LSB 0
`define LCDR_CTRL_PORT_LSB 6
`define LCDR_CTRL_CTL_LSB 10
`define LCDR_CTRL_CTE_BIT 14
`define LCDR_CTRL_SEG_BIT 15
`define LCDR_CTRL_SLP_BIT 16
`define LCDR_CTRL_DT_LSB 17
`define LCDR_DISP_GRP_LSB 30
`define LCDR_DISP_GROUPS 4
`define LCDR_DISP_BITS 480
`define LCDR_DET_FILT_NS 100
`define LCDR_DET_FILT_CYC ((`LCDR_DET_FILT_NS + 9) / 10)
`define LCDR_STAT_RST 32'h0000_0000
`endif

//--- verif/lcdr_far_end.sv
// Purpose: far side model, supply detector pin and key matrix
// Assumes: one clock clk_sys
// Notes: key bus shows a changing pattern when no event is pending
`timescale 1ns/1ps
module lcdr_far_end (
	// clock
	input wire logic clk_sys,
	// commands from bench
	input wire logic supply_low,
	input wire logic key_trig,
	input wire logic [29:0] key_val,
	// pins toward the device
	output logic supply_drop_detector,
	output logic key_event,
	output logic [29:0] key_event_data
);
	logic [29:0] last_r;
	initial begin
		key_event = 1'b0;
		key_event_data = 30'h0000_0000;
		last_r = 30'h0000_0000;
	end
	assign supply_drop_detector = supply_low;
	// idle bus inverts its data every cycle, so a stale capture is seen
	always @(posedge clk_sys) begin
		key_event <= key_trig;
		key_event_data <= key_trig ? key_val : ~key_event_data;
	end
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench of the reset sequencer
// Assumes: FILT_CYC set to 4 for a short run
// Notes: rows cover the post-reset set-up sequence
`timescale 1ns/1ps
module tb;
	logic clk_sys, rst, sup, ktrig, avs_read, avs_write, wreq, det, kev, kdo, koe, disp, ldr, cgr, osc, slp, cte;
	logic [3:0] avs_address, be, gpo, ctl;
	logic [31:0] wd, rd, q;
	logic [29:0] kval, kdat;
	logic [5:0] kso;
	logic [1:0] dty;
	int fails, n_tests, cyc, n;
	typedef struct {logic [3:0] a; logic [31:0] d; logic dsp; logic [3:0] p;} lcdr_row_t;
	lcdr_row_t rows[5] = '{'{4'h0, 32'h0004_56aa, 1'b0, 4'ha}, '{4'h4, 32'h0000_0001, 1'b0, 4'ha},
		'{4'h4, 32'h4000_0002, 1'b0, 4'ha}, '{4'h4, 32'h8000_0003, 1'b0, 4'ha}, '{4'h4, 32'hc000_0004, 1'b1, 4'ha}};
	lcdr_far_end far (.clk_sys(clk_sys), .supply_low(sup), .key_trig(ktrig), .key_val(kval),
		.supply_drop_detector(det), .key_event(kev), .key_event_data(kdat));
	lcdr_reset_seq #(.FILT_CYC(4)) dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rd), .avs_waitrequest(wreq), .supply_drop_detector(det), .key_event(kev),
		.key_event_data(kdat), .key_scan_outputs(kso), .key_data_out_o(kdo), .key_data_out_oe(koe),
		.general_outputs(gpo), .display_on(disp), .lcd_drive_reset(ldr), .clk_gen_reset(cgr),
		.rc_oscillator_pin(osc), .osc_sleep(slp), .contrast_enable_o(cte), .contrast_level_o(ctl),
		.duty_select_o(dty));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until an edge with waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		wd <= d;
		n = 0;
		@(posedge clk_sys);
		while (wreq !== 1'b0 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 50) fails++;
		q = rd;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wait_cgr(input logic v);
		n = 0;
		while (cgr !== v && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		chk(n > 2, 1'b1);
	endtask
	// outputs that every system reset must force
	task chk_locked();
		chk(disp, 1'b0);
		chk(ldr, 1'b1);
		chk(cgr, 1'b1);
		chk(gpo, 4'h0);
		chk(kso, 6'h00);
		chk(koe, 1'b0);
		chk(cte, 1'b0);
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		{avs_read, avs_write, ktrig, fails, n_tests, cyc} = '0;
		{avs_address, wd, kval} = '0;
		be = 4'hf;
		sup = 1'b1;
		rst = 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk_locked();
		sup <= 1'b0;
		wait_cgr(1'b0);
		chk(gpo, 4'h0);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d);
			repeat (2) @(negedge clk_sys);
			chk(disp, rows[i].dsp);
			chk(gpo, rows[i].p);
		end
		chk(kso, 6'h2a);
		chk({cte, ctl, dty, slp}, 8'hac);
		q[0] = osc;
		@(negedge clk_sys);
		chk(q[0] ^ osc, 1'b1);
		@(posedge clk_sys);
		kval <= 30'h1234_5678;
		ktrig <= 1'b1;
		@(posedge clk_sys);
		ktrig <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({koe, kdo}, 2'b10);
		bus(1'b0, 4'hc, 32'h0000_0000);
		chk(q, 32'h1234_5678);
		@(negedge clk_sys);
		chk(koe, 1'b0);
		bus(1'b0, 4'h2, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		// supply droop mid-run
		sup <= 1'b1;
		wait_cgr(1'b1);
		chk_locked();
		bus(1'b0, 4'h8, 32'h0000_0000);
		chk(q[7:0], 8'h01);
		bus(1'b1, 4'h4, 32'h0000_0005);
		bus(1'b1, 4'h0, 32'h0000_0155);
		repeat (2) @(negedge clk_sys);
		chk(gpo, 4'h0);
		bus(1'b0, 4'h0, 32'h0000_0000);
		chk(q, 32'h0000_0155);
		@(posedge clk_sys);
		ktrig <= 1'b1;
		@(posedge clk_sys);
		ktrig <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(koe, 1'b0);
		bus(1'b0, 4'hc, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		close_out();
	end
endmodule
